// [psc_pkg.sv]
// Constants and types for the supply control and status sequencer.
// Assumes a 100 MHz system clock and millisecond interval counting.
package psc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
  localparam int unsigned HOLDUP_US = 300;
  localparam int unsigned HOLDUP_CYCLES = HOLDUP_US * CLK_MHZ;

  localparam logic [11:0] QUAL_MS = 12'd100;
  localparam logic [7:0] DWELL_MIN_MS = 8'd75;
  localparam logic [7:0] DWELL_MAX_MS = 8'd120;
  localparam logic [11:0] VSB_ON_MAX_MS = 12'd1500;
  localparam logic [11:0] VSB_MAIN_MIN_MS = 12'd50;
  localparam logic [11:0] RAMP_MIN_MS = 12'd5;
  localparam logic [11:0] RAMP_MAX_MS = 12'd400;
  localparam logic [11:0] PG_ON_MS = 12'd100;
  localparam logic [11:0] OFF_MIN_MS = 12'd1000;

  localparam logic signed [7:0] OT_WARN_C = 8'sd61;
  localparam logic signed [7:0] FAN_MAX_C = 8'sd58;
  localparam logic signed [7:0] OPER_MAX_C = 8'sd55;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TEMP = 4'h8;
  localparam int unsigned CTRL_FAN_FORCE = 0;
  localparam int unsigned CTRL_FLT_CLR = 1;

  localparam int unsigned FLT_SC = 0;
  localparam int unsigned FLT_OC = 1;
  localparam int unsigned FLT_GEN = 6;
  localparam logic [6:0] FLT_KEEP = 7'h03;

  typedef enum logic [2:0] {
    PSC_OFF, PSC_STBY_WAIT, PSC_STBY, PSC_RAMP,
    PSC_PG_DELAY, PSC_ON, PSC_HOLDUP, PSC_OFF_DWELL
  } psc_state_t;

  typedef struct packed {
    psc_state_t st;
    logic [11:0] ms;
    logic [16:0] tick_cnt;
    logic tick;
    logic [14:0] hold;
    logic [7:0] gcnt;
    logic lost;
    logic ig;
    logic [6:0] flt;
    logic oe_prev;
    logic pg;
    logic main_en;
    logic stby_en;
    logic alert_n;
    logic alert_oe;
    logic fan_max;
    logic ot_warn;
    logic fan_force;
    logic wait_n;
    logic [31:0] rdata;
  } psc_regs_t;
endpackage

// [psc_sequencer.sv]
// Supply control and status sequencer with an Avalon-MM register slave.
// Assumes all status inputs are synchronous to clk_sys.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Main output on while enable input low
// - Enable activity clears latches except short/overcurrent
// - Power good only while outputs regulate; code drops it on main_in_reg loss only, not on standby_in_reg loss
// - Current limit holds power good delay
// - Power good drives high only, wired-OR
// - Alert low on any warning or shutdown
// - Inlet warning at 61C, clears in range
// - Fan at maximum before warning bit sets
// - Input good high on valid input, low overvoltage
// - Input qualified within 100 ms
// - Brownout drops input good, run-length requalification
// - Input good dwell low 75 to 120 ms
// - Input good tracks input and standby promptly
// - Stay off one second after power good drop
// - Main regulation between 5 and 400 ms
// - Power good low within 5 ms of disable
// - Power good 100 to 500 ms after regulation
// - Power good low at least 100 ms per cycle
// - Power good holds 0.3 ms after input loss
// - Alert within 2 ms of input loss
// - Main regulates 50 to 1000 ms after standby
// - Standby within 1500 ms, all within 3000
module psc_sequencer
  import psc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES,
  parameter int unsigned HOLDUP_CNT = HOLDUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic output_enable_n,
  input wire logic input_present,
  input wire logic vin_above_on,
  input wire logic vin_below_off,
  input wire logic vin_overvolt,
  input wire logic standby_in_reg,
  input wire logic main_in_reg,
  input wire logic current_limit,
  input wire logic short_circuit_fault,
  input wire logic overcurrent_fault,
  input wire logic overvolt_det,
  input wire logic undervolt_det,
  input wire logic comp_ot_shutdown,
  input wire logic fan_fail,
  input wire logic comp_ot_warn,
  input wire logic fan_slow,
  input wire logic signed [7:0] inlet_temp,
  output logic standby_enable,
  output logic main_enable,
  output logic power_good_o,
  output logic power_good_oe,
  output logic fault_alert_n_o,
  output logic fault_alert_n_oe,
  output logic input_good,
  output logic fan_max,
  output logic overtemp_warn_bit
);
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [14:0] HOLD_LAST = 15'(HOLDUP_CNT - 1);

  psc_regs_t s;
  psc_regs_t next_s;
  psc_state_t nst;
  logic req;
  logic take;
  logic clr;
  logic [6:0] det;
  logic vin_bad;
  logic warn;

  always_comb begin
    next_s = s;
    nst = s.st;
    det = '0;
    req = avs_read | avs_write;
    take = req & s.wait_n;

    // Millisecond timebase shared by every interval except the holdup count
    next_s.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 17'd1;
    end
    if (s.tick && s.ms != '1) begin
      next_s.ms = s.ms + 12'd1;
    end

    // Avalon slave: one wait cycle, then answer
    next_s.wait_n = req & ~s.wait_n;
    if (req && !s.wait_n) begin
      next_s.rdata = '0;
      unique case (avs_address)
        REG_CTRL: next_s.rdata[CTRL_FAN_FORCE] = s.fan_force;
        REG_STATUS: next_s.rdata = {12'h000, 4'(s.st), 1'b0, s.flt,
          1'b0, s.ot_warn, s.fan_max, s.alert_oe, s.stby_en,
          s.main_en, s.ig, s.pg};
        REG_TEMP: next_s.rdata = {23'h000000, s.ot_warn,
          inlet_temp};
        default: next_s.rdata = '0;
      endcase
    end
    clr = 1'b0;
    if (take && avs_write && avs_address == REG_CTRL && avs_byteenable[0]) begin
      next_s.fan_force = avs_writedata[CTRL_FAN_FORCE];
      clr = avs_writedata[CTRL_FLT_CLR];
    end

    // Fault latches; a new detection wins over a clear
    next_s.oe_prev = output_enable_n;
    if (output_enable_n != s.oe_prev) begin
      clr = 1'b1;
    end
    det = {1'b0, fan_fail, comp_ot_shutdown, undervolt_det,
      overvolt_det, overcurrent_fault, short_circuit_fault};

    // Power-up sequence
    unique case (s.st)
      PSC_OFF: begin
        if (input_present) begin
          nst = PSC_STBY_WAIT;
        end
      end
      PSC_STBY_WAIT: begin
        if (standby_in_reg) begin
          nst = PSC_STBY;
        end else if (s.ms >= VSB_ON_MAX_MS) begin
          det[FLT_GEN] = 1'b1;
        end
      end
      PSC_STBY: begin
        if (s.ms >= VSB_MAIN_MIN_MS && s.ig && !output_enable_n &&
            s.flt == '0 && standby_in_reg) begin
          nst = PSC_RAMP;
        end
      end
      PSC_RAMP: begin
        if (output_enable_n || s.flt != '0) begin
          nst = PSC_STBY;
        end else if (s.ms >= RAMP_MIN_MS && main_in_reg) begin
          nst = PSC_PG_DELAY;
        end else if (s.ms >= RAMP_MAX_MS) begin
          det[FLT_GEN] = 1'b1;
          nst = PSC_STBY;
        end
      end
      PSC_PG_DELAY: begin
        if (output_enable_n || s.flt != '0 || !main_in_reg) begin
          nst = PSC_STBY;
        end else if (s.ms >= PG_ON_MS) begin
          nst = PSC_ON;
        end
      end
      PSC_ON: begin
        if (!input_present) begin
          nst = PSC_HOLDUP;
        end else if (output_enable_n || !main_in_reg || s.flt != '0) begin
          nst = PSC_OFF_DWELL;
        end
      end
      PSC_HOLDUP: begin
        if (s.hold == HOLD_LAST || !main_in_reg) begin
          nst = PSC_OFF_DWELL;
        end
      end
      PSC_OFF_DWELL: begin
        if (s.ms >= OFF_MIN_MS) begin
          nst = input_present ? PSC_STBY_WAIT : PSC_OFF;
        end
      end
    endcase
    if (!input_present && s.st != PSC_ON && s.st != PSC_HOLDUP &&
        s.st != PSC_OFF_DWELL) begin
      nst = PSC_OFF;
    end
    next_s.st = nst;
    if (nst != s.st) begin
      next_s.ms = '0;
    end
    if (s.st == PSC_PG_DELAY && current_limit) begin
      next_s.ms = '0;
    end
    next_s.hold = (s.st == PSC_HOLDUP) ? s.hold + 15'd1 : '0;

    if (clr) begin
      next_s.flt = s.flt & FLT_KEEP;
    end
    next_s.flt = next_s.flt | det;

    next_s.stby_en = input_present;
    next_s.main_en = (nst == PSC_RAMP) || (nst == PSC_PG_DELAY) ||
      (nst == PSC_ON) || (nst == PSC_HOLDUP);
    next_s.pg = (nst == PSC_ON) || (nst == PSC_HOLDUP);

    // Input qualification; simple run-length stands in for the RMS average
    vin_bad = !input_present || vin_below_off || vin_overvolt;
    if (vin_bad) begin
      next_s.ig = 1'b0;
      next_s.gcnt = '0;
      next_s.lost = s.lost | s.ig;
    end else if (!vin_above_on || !standby_in_reg) begin
      next_s.gcnt = '0;
      next_s.ig = s.ig & standby_in_reg;
    end else begin
      if (s.tick && s.gcnt != '1) begin
        next_s.gcnt = s.gcnt + 8'd1;
      end
      if (!s.lost || s.gcnt >= DWELL_MIN_MS) begin
        next_s.ig = 1'b1;
        next_s.lost = 1'b0;
      end
    end

    // Fan goes to maximum one cycle before the warning can set
    next_s.fan_max = s.fan_force || inlet_temp >= FAN_MAX_C ||
      (s.ot_warn && inlet_temp > OPER_MAX_C);
    if (inlet_temp >= OT_WARN_C && s.fan_max) begin
      next_s.ot_warn = 1'b1;
    end else if (inlet_temp <= OPER_MAX_C) begin
      next_s.ot_warn = 1'b0;
    end

    warn = s.ot_warn || comp_ot_warn || fan_slow || current_limit;
    next_s.alert_oe = warn || next_s.flt != '0 || !input_present;
    next_s.alert_n = ~next_s.alert_oe;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
      s.wait_n <= 1'b0;
      s.oe_prev <= 1'b1;
      s.alert_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Wired-OR: power good is only ever driven high, alert only ever driven low
  always_comb begin
    avs_readdata = s.rdata;
    avs_waitrequest = ~s.wait_n;
    standby_enable = s.stby_en;
    main_enable = s.main_en;
    power_good_o = s.pg;
    power_good_oe = s.pg;
    fault_alert_n_o = s.alert_n;
    fault_alert_n_oe = s.alert_oe;
    input_good = s.ig;
    fan_max = s.fan_max;
    overtemp_warn_bit = s.ot_warn;
  end

  property p_pg_off_on_disable;
    @(posedge clk_sys) disable iff (sys_rst)
      (s.st == PSC_ON && output_enable_n && input_present) |=> !power_good_o;
  endproperty
  a_pg_off_on_disable: assert property (p_pg_off_on_disable)
    else $error("power good not dropped after disable");

  property p_delay_held;
    @(posedge clk_sys) disable iff (sys_rst)
      (s.st == PSC_PG_DELAY && current_limit) |=> s.ms == '0;
  endproperty
  a_delay_held: assert property (p_delay_held)
    else $error("power good delay ran in current limit");

  property p_alert_on_loss;
    @(posedge clk_sys) disable iff (sys_rst)
      !input_present |-> ##[1:2] !fault_alert_n_o && fault_alert_n_oe;
  endproperty
  a_alert_on_loss: assert property (p_alert_on_loss)
    else $error("alert missing after input loss");

  property p_holdup;
    @(posedge clk_sys) disable iff (sys_rst)
      (s.st == PSC_ON && !input_present && main_in_reg) |=> power_good_o[*2];
  endproperty
  a_holdup: assert property (p_holdup)
    else $error("power good dropped without holdup");

  property p_main_needs_enable;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(main_enable) |-> $past(!output_enable_n) && $past(s.ms) >= VSB_MAIN_MIN_MS;
  endproperty
  a_main_needs_enable: assert property (p_main_needs_enable)
    else $error("main enabled without enable input");

  property p_scp_kept;
    @(posedge clk_sys) disable iff (sys_rst)
      s.flt[FLT_SC] |=> s.flt[FLT_SC];
  endproperty
  a_scp_kept: assert property (p_scp_kept)
    else $error("short circuit latch cleared");

  property p_dwell;
    @(posedge clk_sys) disable iff (sys_rst)
      ($rose(input_good) && $past(s.lost)) |-> $past(s.gcnt) >= DWELL_MIN_MS;
  endproperty
  a_dwell: assert property (p_dwell)
    else $error("input good dwell too short");

  property p_pg_on_delay;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(power_good_o) |-> $past(s.st) == PSC_PG_DELAY && $past(s.ms) >= PG_ON_MS;
  endproperty
  a_pg_on_delay: assert property (p_pg_on_delay)
    else $error("power good asserted early");

  property p_fan_first;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(overtemp_warn_bit) |-> $past(fan_max);
  endproperty
  a_fan_first: assert property (p_fan_first)
    else $error("warning set before fan at maximum");

  property p_alert_on_fault;
    @(posedge clk_sys) disable iff (sys_rst)
      (s.flt != '0) |-> !fault_alert_n_o;
  endproperty
  a_alert_on_fault: assert property (p_alert_on_fault)
    else $error("alert high with latched fault");

  property p_off_min;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(power_good_o) |-> !main_enable [*8];
  endproperty
  a_off_min: assert property (p_off_min)
    else $error("main restarted too soon");
endmodule // psc_sequencer

// [psc_host_model.sv]
// Host power controller model: drives the enable pin, resolves shared pins.
// Assumes a board pull-down on power good and a pull-up on alert.
`timescale 1ns/1ps
module psc_host_model
  import psc_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = 10000
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic want_on,
  input wire logic obey,
  input wire logic power_good_o,
  input wire logic power_good_oe,
  input wire logic fault_alert_n_o,
  input wire logic fault_alert_n_oe,
  output logic output_enable_n,
  output logic power_good,
  output logic fault_alert_n
);
  logic pg_q;
  int unsigned off_cnt;
  // Released pins fall to the board resistor level
  assign power_good = power_good_oe ? power_good_o : 1'b0;
  assign fault_alert_n = fault_alert_n_oe ? fault_alert_n_o : 1'b1;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pg_q <= 1'b0;
      off_cnt <= 0;
      output_enable_n <= 1'b1;
    end else begin
      pg_q <= power_good;
      if (pg_q && !power_good) off_cnt <= OFF_CYCLES;
      else if (off_cnt != 0) off_cnt <= off_cnt - 1;
      // Clearing obey lets a scenario break the hold-off on purpose
      output_enable_n <= !(want_on && (off_cnt == 0 || !obey));
    end
  end
endmodule // psc_host_model

// [psc_sequencer_bench.sv]
// Self-checking bench for the supply sequencer and its register slave.
// Assumes shortened timebase: one millisecond is TICK clock cycles.
`timescale 1ns/1ps
module psc_sequencer_bench
  import psc_pkg::*;
;
  localparam int TICK = 10;
  localparam int HOLD = 4;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic want_on = 1'b0;
  logic obey = 1'b1;
  logic input_present = 1'b0;
  logic vin_above_on = 1'b0;
  logic vin_below_off = 1'b0;
  logic vin_overvolt = 1'b0;
  logic standby_in_reg = 1'b0;
  logic main_in_reg = 1'b0;
  logic current_limit = 1'b0;
  logic [7:0] det = 8'h0;
  logic signed [7:0] inlet_temp = 8'sh19;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, output_enable_n, pg_o, pg_oe, al_o, al_oe, power_good, fault_alert_n;
  wire standby_enable, main_enable, input_good, fan_max, overtemp_warn_bit;
  wire [6:0] obs = {overtemp_warn_bit, fan_max, standby_enable, main_enable, input_good, fault_alert_n, power_good};
  int err_count = 0;
  int checks_done = 0;
  int n, m, i;
  logic [31:0] q;
  logic [7:0] tv [4] = '{8'h39, 8'h3d, 8'h38, 8'h37};
  logic [3:0] wv = 4'b0110;

  psc_sequencer #(.TICK_CYCLES(TICK), .HOLDUP_CNT(HOLD)) u_psc_sequencer (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .output_enable_n(output_enable_n),
    .input_present(input_present), .vin_above_on(vin_above_on), .vin_below_off(vin_below_off),
    .vin_overvolt(vin_overvolt), .standby_in_reg(standby_in_reg), .main_in_reg(main_in_reg),
    .current_limit(current_limit), .short_circuit_fault(det[0]), .overcurrent_fault(det[1]),
    .overvolt_det(det[2]), .undervolt_det(det[3]), .comp_ot_shutdown(det[4]), .fan_fail(det[5]),
    .comp_ot_warn(det[6]), .fan_slow(det[7]), .inlet_temp(inlet_temp), .standby_enable(standby_enable),
    .main_enable(main_enable), .power_good_o(pg_o), .power_good_oe(pg_oe), .fault_alert_n_o(al_o),
    .fault_alert_n_oe(al_oe), .input_good(input_good), .fan_max(fan_max), .overtemp_warn_bit(overtemp_warn_bit));

  psc_host_model #(.OFF_CYCLES(1000 * TICK)) u_psc_host_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .want_on(want_on), .obey(obey), .power_good_o(pg_o),
    .power_good_oe(pg_oe), .fault_alert_n_o(al_o), .fault_alert_n_oe(al_oe),
    .output_enable_n(output_enable_n), .power_good(power_good), .fault_alert_n(fault_alert_n));

  always #5 clk_sys = ~clk_sys;

  task tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task ok(input logic c);
    check({31'h0, c}, 32'h1);
  endtask

  // Request held until the edge at which waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Counts cycles until an observed output takes a level
  task wait_v(input int k, input logic v);
    n = 1;
    @(negedge clk_sys);
    while (obs[k] !== v) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task report_and_stop;
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    tick(60000);
    err_count++;
    report_and_stop;
  end

  initial begin
    tick(12);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check({25'h0, obs & 7'h7d}, 32'h0);
    bus(0, 4'hc, 32'h0);
    check(q, 32'h0);
    bus(0, 4'h8, 32'h0);
    check(q, 32'h19);
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h0, 32'h0);
    check(q, 32'h1);
    avs_byteenable <= 4'he;
    bus(1, 4'h0, 32'h0);
    ok(fan_max);
    avs_byteenable <= 4'hf;
    bus(1, 4'h0, 32'h0);
    for (i = 0; i < 4; i++) begin
      tick(1);
      inlet_temp <= tv[i];
      tick(4);
      @(negedge clk_sys);
      check({31'h0, overtemp_warn_bit}, {31'h0, wv[i]});
      if (wv[i]) ok(fan_max);
    end
    tick(1);
    inlet_temp <= 8'sh19;
    input_present <= 1'b1;
    standby_in_reg <= 1'b1;
    vin_above_on <= 1'b1;
    wait_v(4, 1'b1);
    wait_v(2, 1'b1);
    ok(n <= 20 * TICK);
    tick(1);
    want_on <= 1'b1;
    wait_v(3, 1'b1);
    ok(n >= 48 * TICK && n <= 1000 * TICK);
    tick(1);
    main_in_reg <= 1'b1;
    current_limit <= 1'b1;
    tick(30 * TICK);
    @(negedge clk_sys);
    ok(!fault_alert_n && !power_good);
    tick(1);
    current_limit <= 1'b0;
    wait_v(0, 1'b1);
    ok(n >= 99 * TICK && n <= 500 * TICK);
    check({30'h0, pg_oe, pg_o}, 32'h3);
    bus(0, 4'h4, 32'h0);
    check(q & 32'hf000f, 32'h5000f);
    want_on <= 1'b0;
    wait_v(0, 1'b0);
    ok(n <= 5 * TICK);
    check({30'h0, pg_oe, pg_o}, 32'h0);
    tick(2);
    ok(!main_enable);
    obey <= 1'b0;
    want_on <= 1'b1;
    wait_v(3, 1'b1);
    ok(n >= 990 * TICK);
    tick(1);
    obey <= 1'b1;
    wait_v(0, 1'b1);
    tick(1);
    input_present <= 1'b0;
    wait_v(0, 1'b0);
    ok(n >= HOLD - 1);
    ok(n <= 2 * TICK && !fault_alert_n);
    tick(1);
    input_present <= 1'b1;
    wait_v(2, 1'b1);
    tick(1);
    vin_below_off <= 1'b1;
    vin_above_on <= 1'b0;
    wait_v(2, 1'b0);
    ok(n <= 3);
    tick(1);
    vin_below_off <= 1'b0;
    vin_above_on <= 1'b1;
    wait_v(2, 1'b1);
    ok(n >= 74 * TICK && n <= 120 * TICK);
    tick(1);
    vin_overvolt <= 1'b1;
    wait_v(2, 1'b0);
    ok(n <= 3);
    tick(1);
    vin_overvolt <= 1'b0;
    for (i = 0; i < 6; i++) begin
      tick(1);
      det <= 8'h1 << i;
      tick(1);
      det <= 8'h0;
      bus(0, 4'h4, 32'h0);
      check({26'h0, q[13:8]}, (32'h2 << i) - 32'h1);
      ok(!fault_alert_n);
    end
    // Enable follows want_on directly so the toggle is sure to happen
    obey <= 1'b0;
    want_on <= 1'b0;
    tick(3);
    want_on <= 1'b1;
    tick(3);
    bus(0, 4'h4, 32'h0);
    check({26'h0, q[13:8]}, 32'h3);
    report_and_stop;
  end
endmodule // psc_sequencer_bench
